//--- hdl/phoc_pkg.sv
// Package: constants and types of the peak hold and output control block
package phoc_pkg;

    localparam int PHOC_DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] PHOC_OFF_CTRL = 8'h00;
    localparam logic [7:0] PHOC_OFF_SAMPLE = 8'h04;
    localparam logic [7:0] PHOC_OFF_ABS_UPPER = 8'h08;
    localparam logic [7:0] PHOC_OFF_ABS_LOWER = 8'h0C;
    localparam logic [7:0] PHOC_OFF_INC_UPPER = 8'h10;
    localparam logic [7:0] PHOC_OFF_INC_LOWER = 8'h14;
    localparam logic [7:0] PHOC_OFF_PRESET = 8'h18;
    localparam logic [7:0] PHOC_OFF_KEYS = 8'h1C;
    localparam logic [7:0] PHOC_OFF_STATUS = 8'h20;
    localparam logic [7:0] PHOC_OFF_SHOWN = 8'h24;
    localparam logic [7:0] PHOC_OFF_MAX = 8'h28;
    localparam logic [7:0] PHOC_OFF_MIN = 8'h2C;
    localparam logic [7:0] PHOC_OFF_WIDTH = 8'h30;
    localparam logic [7:0] PHOC_OFF_OUTVAL = 8'h34;

    // CTRL field positions
    localparam int PHOC_CTRL_MODE_LSB = 0;
    localparam int PHOC_CTRL_INC_BIT = 2;
    localparam int PHOC_CTRL_AUTO_BAR_BIT = 3;
    localparam int PHOC_CTRL_TOL_LSB = 4;
    localparam int PHOC_CTRL_EXT_BIT = 6;
    localparam int PHOC_CTRL_MAP1_LSB = 8;
    localparam int PHOC_CTRL_MAP2_LSB = 11;
    localparam int PHOC_CTRL_MAP3_LSB = 14;
    localparam int PHOC_CTRL_RESCALE_BIT = 17;
    localparam int PHOC_CTRL_SCALE_LSB = 24;

    // KEYS write field positions (pulses)
    localparam int PHOC_KEY_ONE_BIT = 0;
    localparam int PHOC_KEY_TWO_BIT = 1;
    localparam int PHOC_KEY_THREE_BIT = 2;
    localparam int PHOC_KEY_REQ_BIT = 3;

    localparam logic [31:0] PHOC_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] PHOC_ZERO = 32'h0000_0000;
    localparam logic [7:0] PHOC_BAR_SPAN_RST = 8'h10;
    localparam logic [3:0] PHOC_BLINK_CYC = 4'hF;

    // AXI responses
    localparam logic [1:0] PHOC_RESP_OKAY = 2'b00;
    localparam logic [1:0] PHOC_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        PHOC_STD1 = 2'b00,
        PHOC_STD2 = 2'b01,
        PHOC_PEAK = 2'b10
    } phoc_mode_t;

    typedef enum logic [1:0] {
        PHOC_SHOW_CUR = 2'b00,
        PHOC_SHOW_WIDTH = 2'b01,
        PHOC_SHOW_MAX = 2'b10,
        PHOC_SHOW_MIN = 2'b11
    } phoc_show_t;

    typedef enum logic [2:0] {
        PHOC_FN_NONE = 3'b000,
        PHOC_FN_ZERO = 3'b001,
        PHOC_FN_PRESET = 3'b010,
        PHOC_FN_DIR = 3'b011,
        PHOC_FN_HOLD = 3'b100
    } phoc_fn_t;

    typedef enum logic [1:0] {
        PHOC_TOL_OFF = 2'b00,
        PHOC_TOL_NORMAL = 2'b01,
        PHOC_TOL_LARGE = 2'b10
    } phoc_tol_t;

    // Upper and lower limits travel together
    typedef struct packed {
        logic signed [31:0] upper;
        logic signed [31:0] lower;
    } phoc_limits_t;

    typedef struct packed {
        logic max_blink;
        logic min_blink;
        logic hold;
        logic go;
        logic ng;
    } phoc_ind_t;

endpackage

//--- hdl/phoc_top.sv
// Peak hold, tolerance, hold and output trigger logic with AXI4-Lite access
//
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
module phoc_top
    import phoc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sample_valid,
    input wire logic signed [31:0] sample_value,
    output logic signed [31:0] shown_value_r,
    output logic max_blink_r,
    output logic min_blink_r,
    output logic hold_ind_r,
    output logic tol_go_r,
    output logic tol_ng_r,
    output logic bar_recentre_r,
    output logic [7:0] bar_span_r,
    output logic out_send_r,
    output logic signed [31:0] out_value_r,
    output logic count_dir_r
);

    if (ADDR_W < 6) begin : g_chk
        $error("ADDR_W must cover the register map");
    end

    // Register storage
    logic [31:0] ctrl_r;
    logic signed [31:0] cur_r;
    phoc_limits_t abs_lim_r, inc_lim_r;
    logic signed [31:0] preset_r;
    logic signed [31:0] max_r, min_r;
    logic signed [31:0] held_max_r, held_min_r, held_cur_r;
    logic tracking_r;
    phoc_show_t show_r;
    logic [1:0] mode_prev_r;
    logic key1_p, key2_p, key3_p, req_p;
    logic [3:0] max_cnt_r, min_cnt_r;

    phoc_mode_t mode;
    phoc_tol_t tol_mode;
    logic ext_conn, auto_bar;
    assign mode = phoc_mode_t'(ctrl_r[PHOC_CTRL_MODE_LSB +: 2]);
    assign tol_mode = phoc_tol_t'(ctrl_r[PHOC_CTRL_TOL_LSB +: 2]);
    assign ext_conn = ctrl_r[PHOC_CTRL_EXT_BIT];
    assign auto_bar = ctrl_r[PHOC_CTRL_AUTO_BAR_BIT];

    // AXI write path: address and data taken in either order
    logic aw_have_r, w_have_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_go;
    assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
    assign s_axi_wready = ~w_have_r & ~s_axi_bvalid;
    assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= PHOC_ZERO;
            w_strb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
            end
        end
    end

    logic [7:0] waddr;
    logic wr_hit;
    assign waddr = 8'(aw_addr_r);
    always_comb begin
        if (waddr == PHOC_OFF_CTRL || waddr == PHOC_OFF_SAMPLE) begin
            wr_hit = 1'b1;
        end else if (waddr >= PHOC_OFF_ABS_UPPER && waddr <= PHOC_OFF_KEYS
                     && waddr[1:0] == 2'b00) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) res[8*i +: 8] = nw[8*i +: 8];
        end
        return res;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PHOC_RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? PHOC_RESP_OKAY : PHOC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    logic wr_ctrl, wr_keys;
    assign wr_ctrl = wr_go && waddr == PHOC_OFF_CTRL;
    assign wr_keys = wr_go && waddr == PHOC_OFF_KEYS && w_strb_r[0];

    // Keys and the external request are one-cycle pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key1_p <= 1'b0;
            key2_p <= 1'b0;
            key3_p <= 1'b0;
            req_p <= 1'b0;
        end else begin
            key1_p <= wr_keys & w_data_r[PHOC_KEY_ONE_BIT];
            key2_p <= wr_keys & w_data_r[PHOC_KEY_TWO_BIT];
            key3_p <= wr_keys & w_data_r[PHOC_KEY_THREE_BIT];
            req_p <= wr_keys & w_data_r[PHOC_KEY_REQ_BIT];
        end
    end

    // Effective key functions
    phoc_fn_t fn2, fn3;
    always_comb begin
        if (mode == PHOC_STD1) begin
            fn2 = phoc_fn_t'(ctrl_r[PHOC_CTRL_MAP2_LSB +: 3]);
            fn3 = phoc_fn_t'(ctrl_r[PHOC_CTRL_MAP3_LSB +: 3]);
        end else begin
            fn2 = PHOC_FN_ZERO;
            fn3 = PHOC_FN_HOLD;
        end
    end
    phoc_fn_t fn1;
    assign fn1 = (mode == PHOC_STD1) ?
                 phoc_fn_t'(ctrl_r[PHOC_CTRL_MAP1_LSB +: 3]) : PHOC_FN_NONE;

    logic fn_dir, fn_preset, fn_zero;
    assign fn_dir = (key1_p && fn1 == PHOC_FN_DIR) ||
                    (key2_p && fn2 == PHOC_FN_DIR) ||
                    (key3_p && fn3 == PHOC_FN_DIR);
    assign fn_preset = (key1_p && fn1 == PHOC_FN_PRESET) ||
                       (key2_p && fn2 == PHOC_FN_PRESET) ||
                       (key3_p && fn3 == PHOC_FN_PRESET);
    assign fn_zero = mode != PHOC_PEAK && ((key1_p && fn1 == PHOC_FN_ZERO) ||
                     (key2_p && fn2 == PHOC_FN_ZERO) ||
                     (key3_p && fn3 == PHOC_FN_ZERO));
    logic hold_key;
    assign hold_key = (key1_p && fn1 == PHOC_FN_HOLD) ||
                      (key2_p && fn2 == PHOC_FN_HOLD) ||
                      (key3_p && fn3 == PHOC_FN_HOLD);

    // Control, limits and preset registers
    logic rescale;
    assign rescale = wr_ctrl && w_data_r[PHOC_CTRL_RESCALE_BIT];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= PHOC_CTRL_RST;
            abs_lim_r <= '0;
            inc_lim_r <= '0;
            preset_r <= PHOC_ZERO;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r);
                ctrl_r[PHOC_CTRL_RESCALE_BIT] <= 1'b0;
            end
            if (wr_go && waddr == PHOC_OFF_ABS_UPPER)
                abs_lim_r.upper <= merge(abs_lim_r.upper, w_data_r, w_strb_r);
            if (wr_go && waddr == PHOC_OFF_ABS_LOWER)
                abs_lim_r.lower <= merge(abs_lim_r.lower, w_data_r, w_strb_r);
            if (wr_go && waddr == PHOC_OFF_INC_UPPER)
                inc_lim_r.upper <= merge(inc_lim_r.upper, w_data_r, w_strb_r);
            if (wr_go && waddr == PHOC_OFF_INC_LOWER)
                inc_lim_r.lower <= merge(inc_lim_r.lower, w_data_r, w_strb_r);
            if (wr_go && waddr == PHOC_OFF_PRESET)
                preset_r <= merge(preset_r, w_data_r, w_strb_r);
            // rescale by signed factor in sixteenths on unit change
            else if (rescale)
                preset_r <= 32'((64'(preset_r) *
                    64'(signed'(w_data_r[PHOC_CTRL_SCALE_LSB +: 8]))) >>> 4);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_dir_r <= 1'b0;
        end else if (fn_dir) begin
            count_dir_r <= ~count_dir_r;
        end
    end

    // Measured sample, with zero and preset recall acting on it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_r <= PHOC_ZERO;
        end else if (fn_zero) begin
            cur_r <= PHOC_ZERO;
        end else if (fn_preset) begin
            cur_r <= preset_r;
        end else if (sample_valid) begin
            cur_r <= sample_value;
        end else if (wr_go && waddr == PHOC_OFF_SAMPLE) begin
            cur_r <= w_data_r;
        end
    end

    // Peak tracking
    logic peak_enter, restart, new_max, new_min;
    assign peak_enter = mode == PHOC_PEAK && mode_prev_r != PHOC_PEAK;
    assign restart = peak_enter || (mode == PHOC_PEAK && key2_p);
    assign new_max = tracking_r && !restart && cur_r > max_r;
    assign new_min = tracking_r && !restart && cur_r < min_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_prev_r <= PHOC_STD1;
            tracking_r <= 1'b0;
            max_r <= PHOC_ZERO;
            min_r <= PHOC_ZERO;
        end else begin
            mode_prev_r <= mode;
            if (restart) begin
                tracking_r <= 1'b1;
                max_r <= cur_r;
                min_r <= cur_r;
            end else if (mode != PHOC_PEAK) begin
                tracking_r <= 1'b0;
            end else begin
                if (new_max) max_r <= cur_r;
                if (new_min) min_r <= cur_r;
            end
        end
    end

    logic signed [31:0] width;
    assign width = 32'(held_max_r - held_min_r);

    // Display selection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            show_r <= PHOC_SHOW_CUR;
        end else if (mode != PHOC_PEAK) begin
            show_r <= PHOC_SHOW_CUR;
        end else if (key1_p) begin
            case (show_r)
                PHOC_SHOW_CUR: show_r <= PHOC_SHOW_WIDTH;
                PHOC_SHOW_WIDTH: show_r <= PHOC_SHOW_MAX;
                PHOC_SHOW_MAX: show_r <= PHOC_SHOW_MIN;
                default: show_r <= hold_ind_r ? PHOC_SHOW_WIDTH
                                              : PHOC_SHOW_CUR;
            endcase
        end
    end

    // Hold
    logic hold_ok;
    assign hold_ok = !ext_conn && tol_mode != PHOC_TOL_LARGE;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_ind_r <= 1'b0;
        end else if (hold_key && hold_ok) begin
            hold_ind_r <= ~hold_ind_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            held_cur_r <= PHOC_ZERO;
            held_max_r <= PHOC_ZERO;
            held_min_r <= PHOC_ZERO;
        end else if (!hold_ind_r) begin
            held_cur_r <= cur_r;
            held_max_r <= max_r;
            held_min_r <= min_r;
        end
    end

    logic signed [31:0] shown;
    always_comb begin
        case (show_r)
            PHOC_SHOW_WIDTH: shown = width;
            PHOC_SHOW_MAX: shown = held_max_r;
            PHOC_SHOW_MIN: shown = held_min_r;
            default: shown = held_cur_r;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shown_value_r <= PHOC_ZERO;
        end else begin
            shown_value_r <= shown;
        end
    end

    // Indicator blink stretch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            max_cnt_r <= 4'h0;
            min_cnt_r <= 4'h0;
        end else begin
            if (new_max && (show_r == PHOC_SHOW_WIDTH ||
                            show_r == PHOC_SHOW_MAX))
                max_cnt_r <= PHOC_BLINK_CYC;
            else if (max_cnt_r != 4'h0)
                max_cnt_r <= max_cnt_r - 4'h1;
            if (new_min && (show_r == PHOC_SHOW_WIDTH ||
                            show_r == PHOC_SHOW_MIN))
                min_cnt_r <= PHOC_BLINK_CYC;
            else if (min_cnt_r != 4'h0)
                min_cnt_r <= min_cnt_r - 4'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            max_blink_r <= 1'b0;
            min_blink_r <= 1'b0;
        end else begin
            max_blink_r <= max_cnt_r != 4'h0;
            min_blink_r <= min_cnt_r != 4'h0;
        end
    end

    // Tolerance judgment
    phoc_limits_t lim;
    assign lim = ctrl_r[PHOC_CTRL_INC_BIT] ? inc_lim_r : abs_lim_r;
    logic pass;
    always_comb begin
        if (show_r == PHOC_SHOW_WIDTH) begin
            pass = width <= 32'(lim.upper - lim.lower);
        end else begin
            pass = shown <= lim.upper && shown >= lim.lower;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tol_go_r <= 1'b0;
            tol_ng_r <= 1'b0;
        end else begin
            tol_go_r <= tol_mode != PHOC_TOL_OFF && pass;
            tol_ng_r <= tol_mode != PHOC_TOL_OFF && !pass;
        end
    end

    // Bar scale and recentring
    logic signed [31:0] bar_ref_r;
    logic signed [31:0] bar_off;
    logic bar_out;
    // Span kept signed so negative offsets compare right
    logic signed [31:0] bar_lim;
    assign bar_off = 32'(shown - bar_ref_r);
    assign bar_lim = signed'({24'h0, bar_span_r});
    assign bar_out = bar_off > bar_lim || bar_off < -bar_lim;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bar_ref_r <= PHOC_ZERO;
            bar_span_r <= PHOC_BAR_SPAN_RST;
            bar_recentre_r <= 1'b0;
        end else begin
            bar_recentre_r <= 1'b0;
            if (bar_out && show_r == PHOC_SHOW_WIDTH && auto_bar) begin
                if (bar_span_r < 8'h80) bar_span_r <= {bar_span_r[6:0], 1'b0};
                else bar_ref_r <= shown;
            end else if (bar_out && (show_r == PHOC_SHOW_MAX ||
                                     show_r == PHOC_SHOW_MIN)) begin
                bar_ref_r <= shown;
                bar_recentre_r <= 1'b1;
            end
        end
    end

    // External output trigger
    logic send;
    always_comb begin
        if (tol_mode == PHOC_TOL_LARGE) begin
            send = req_p;
        end else begin
            send = req_p || (key3_p && ext_conn);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            out_send_r <= 1'b0;
            out_value_r <= PHOC_ZERO;
        end else begin
            out_send_r <= send;
            if (send) out_value_r <= shown;
        end
    end

    // Read path
    logic [7:0] raddr;
    logic [31:0] rd;
    logic rd_hit;
    assign raddr = 8'(s_axi_araddr);
    assign s_axi_arready = ~s_axi_rvalid;
    always_comb begin
        rd_hit = 1'b1;
        if (raddr == PHOC_OFF_CTRL) rd = ctrl_r;
        else if (raddr == PHOC_OFF_SAMPLE) rd = cur_r;
        else if (raddr == PHOC_OFF_ABS_UPPER) rd = abs_lim_r.upper;
        else if (raddr == PHOC_OFF_ABS_LOWER) rd = abs_lim_r.lower;
        else if (raddr == PHOC_OFF_INC_UPPER) rd = inc_lim_r.upper;
        else if (raddr == PHOC_OFF_INC_LOWER) rd = inc_lim_r.lower;
        else if (raddr == PHOC_OFF_PRESET) rd = preset_r;
        else if (raddr == PHOC_OFF_KEYS) rd = PHOC_ZERO;
        else if (raddr == PHOC_OFF_STATUS)
            rd = {22'h0, count_dir_r, tracking_r, show_r, hold_ind_r,
                  max_blink_r, min_blink_r, tol_go_r, tol_ng_r,
                  bar_recentre_r};
        else if (raddr == PHOC_OFF_SHOWN) rd = shown_value_r;
        else if (raddr == PHOC_OFF_MAX) rd = held_max_r;
        else if (raddr == PHOC_OFF_MIN) rd = held_min_r;
        else if (raddr == PHOC_OFF_WIDTH) rd = width;
        else if (raddr == PHOC_OFF_OUTVAL) rd = out_value_r;
        else begin
            rd = PHOC_ZERO;
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= PHOC_ZERO;
            s_axi_rresp <= PHOC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd;
            s_axi_rresp <= rd_hit ? PHOC_RESP_OKAY : PHOC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

//--- testbench/phoc_ext_model.sv
// Far-side display or printer model that captures sent values
module phoc_ext_model (
    input wire logic aclk,
    input wire logic out_send_r,
    input wire logic signed [31:0] out_value_r,
    output logic [31:0] got,
    output int sends
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    assign sends = cnt;
    // Capture on each send pulse
    always @(posedge aclk) begin
        if (out_send_r === 1'b1) begin
            got <= out_value_r;
            cnt <= cnt + 1;
        end
    end
endmodule

//--- testbench/phoc_top_sva.sv
// Port checker for the peak hold block
module phoc_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic signed [31:0] shown_value_r,
    input wire logic max_blink_r,
    input wire logic min_blink_r,
    input wire logic bar_recentre_r,
    input wire logic hold_ind_r,
    input wire logic tol_go_r,
    input wire logic tol_ng_r,
    input wire logic out_send_r,
    input wire logic signed [31:0] out_value_r
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    write_done_a: assert property (s_axi_bvalid && s_axi_bready |=>
        !s_axi_bvalid) else $error("bvalid stuck");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid) else $error("rvalid stuck");
    send_pulse_a: assert property (out_send_r |=> !out_send_r)
        else $error("send not a pulse");
    go_ng_a: assert property (!(tol_go_r && tol_ng_r))
        else $error("go and ng together");
    hold_cause_a: assert property ($changed(hold_ind_r) |->
        $past(s_axi_bvalid)) else $error("hold moved alone");
    held_frozen_a: assert property (hold_ind_r && $past(hold_ind_r) &&
        !$past(s_axi_bvalid) && !$past(s_axi_bvalid, 2) |->
        $stable(shown_value_r)) else $error("held value moved");
    blink_len_a: assert property ($rose(max_blink_r) |=>
        max_blink_r[*8]) else $error("blink too short");
    min_blink_a: assert property ($rose(min_blink_r) |=>
        min_blink_r[*8]) else $error("min blink too short");
    send_latch_a: assert property ($changed(out_value_r) |->
        out_send_r) else $error("out value moved");
    cover property (out_send_r);
    cover property ($rose(hold_ind_r));
    cover property ($rose(max_blink_r));
    cover property (bar_recentre_r);
endmodule
bind phoc_top phoc_sva chk (.*);

//--- testbench/tb_peak_hold_output_control.sv
// Self-checking bench for the peak hold block
module tb_peak_hold_output_control
    import phoc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, sample_valid;
    logic max_blink_r, min_blink_r, hold_ind_r, tol_go_r, tol_ng_r;
    logic bar_recentre_r, out_send_r, count_dir_r;
    logic [7:0] s_axi_awaddr, s_axi_araddr, bar_span_r;
    logic [31:0] s_axi_wdata, s_axi_rdata, got, lf;
    logic signed [31:0] sample_value, shown_value_r, out_value_r, mx, mn;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [33:0] exp_q[$];
    logic [33:0] exp_now;
    int miscompares, checks_done, sends;
    `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
        miscompares++; $display("mismatch %0t %h %h", $time, a, b); end end
    phoc_top dut (.*);
    phoc_ext_model ext (.*);
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] r = 2'b00);
        exp_q.push_back({r, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
    endtask
    task automatic key(input int b);
        wr(PHOC_OFF_KEYS, 32'h1 << b);
        repeat (2) @(posedge aclk);
    endtask
    // Held extremes settle three edges after the sample
    task automatic smp(input logic signed [31:0] v);
        sample_valid <= 1'b1;
        sample_value <= v;
        @(posedge aclk);
        sample_valid <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
            exp_now = exp_q.pop_front();
            `CHK({s_axi_rresp, s_axi_rdata}, exp_now)
        end
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        end_of_test();
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {sample_valid, sample_value} = 33'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
        lf = 32'h9;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(PHOC_OFF_PRESET, 32'h0);
        wr(PHOC_OFF_ABS_UPPER, 32'h64);
        wr(PHOC_OFF_ABS_LOWER, 32'hFFFF_FF9C);
        wr(PHOC_OFF_CTRL, 32'h12);
        key(1);
        {mx, mn} = 64'h0;
        for (int i = 0; i < 12; i++) begin
            lf = lfsr(lf);
            smp($signed({{24{lf[7]}}, lf[7:0]}));
            if (sample_value > mx) mx = sample_value;
            if (sample_value < mn) mn = sample_value;
        end
        rd(PHOC_OFF_MAX, mx);
        rd(PHOC_OFF_MIN, mn);
        key(0);
        rd(PHOC_OFF_SHOWN, mx - mn);
        `CHK(tol_go_r, (mx - mn <= 200))
        `CHK(tol_ng_r, !(mx - mn <= 200))
        key(0);
        rd(PHOC_OFF_SHOWN, mx);
        `CHK(tol_go_r, (mx <= 100 && mx >= -100))
        smp(mx + 1);
        `CHK(max_blink_r, 1'b1)
        key(0);
        rd(PHOC_OFF_SHOWN, mn);
        smp(mn - 1);
        `CHK(min_blink_r, 1'b1)
        key(1);
        rd(PHOC_OFF_MAX, mn - 1);
        key(2);
        `CHK(hold_ind_r, 1'b1)
        smp(mn - 50);
        rd(PHOC_OFF_SHOWN, mn - 1);
        key(2);
        `CHK(hold_ind_r, 1'b0)
        smp(mn - 60);
        wr(PHOC_OFF_CTRL, 32'h52);
        key(2);
        `CHK(got, mn - 60)
        `CHK(hold_ind_r, 1'b0)
        wr(PHOC_OFF_CTRL, 32'h61);
        key(2);
        `CHK(sends, 1)
        key(3);
        `CHK(sends, 2)
        `CHK(bar_span_r, PHOC_BAR_SPAN_RST)
        wr(PHOC_OFF_PRESET, 32'h10);
        wr(PHOC_OFF_CTRL, 32'h2002_0000);
        rd(PHOC_OFF_PRESET, 32'h20);
        wr(PHOC_OFF_CTRL, 32'h301);
        key(0);
        `CHK(count_dir_r, 1'b0)
        wr(PHOC_OFF_CTRL, 32'h300);
        key(0);
        `CHK(count_dir_r, 1'b1)
        rd(8'h3C, 32'h0, 2'b10);
        repeat (4) @(posedge aclk);
        end_of_test();
    end
endmodule
